// >>> rtl/psl_defines.svh
`ifndef PSL_DEFINES_SVH
`define PSL_DEFINES_SVH

// key bytes that must precede a lock bit write
`define PSL_KEY_FIRST 8'h55
`define PSL_KEY_SECOND 8'haa
// position of the lock bit in the lock control register
`define PSL_LOCK_BIT 0
// selection table shape
`define PSL_SEL_COUNT 16
`define PSL_SEL_WIDTH 6
`define PSL_SEL_AW 4
// default selection after power-on
`define PSL_SEL_DEFAULT 6'h00
`define PSL_IDX_MAX 4'hf

`endif

// >>> rtl/psl_lock_ctrl.sv
`timescale 1ns/10ps
`include "psl_defines.svh"

module psl_lock_ctrl
    import psl_pkg::*;
(
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic por,
    // sleep indication, no effect on selections
    input wire logic sleep,
    // one-way lock configuration strap
    input wire logic one_way_lock_option,
    // lock control register write
    input wire logic lock_wr,
    input wire logic [7:0] lock_wdata,
    // selection write and read
    input wire logic sel_wr,
    input wire logic [`PSL_SEL_AW-1:0] sel_idx,
    input wire logic [`PSL_SEL_WIDTH-1:0] sel_wdata,
    input wire logic [`PSL_SEL_AW-1:0] sel_rd_idx,
    output logic [`PSL_SEL_WIDTH-1:0] sel_rdata,
    // status
    output logic selection_lock_bit,
    output logic key_armed,
    output logic sel_wr_blocked
);

    // any reset source, por included, clears the lock logic
    logic any_reset;
    assign any_reset = reset | por;

    psl_key_state_t key_state;
    psl_key_state_t next_key_state;
    psl_ow_state_t ow_state;
    psl_ow_state_t next_ow_state;
    logic next_lock;
    logic next_blocked;
    logic want_lock;
    logic sel_wr_ok;

    assign want_lock = lock_wdata[`PSL_LOCK_BIT];

    // ==========================================
    // key sequence
    always_comb begin
        next_key_state = key_state;
        if (lock_wr) begin
            unique case (key_state)
                PSL_KEY_IDLE: begin
                    next_key_state = (lock_wdata == `PSL_KEY_FIRST) ? PSL_KEY_GOT_FIRST : PSL_KEY_IDLE;
                end
                PSL_KEY_GOT_FIRST: begin
                    next_key_state = (lock_wdata == `PSL_KEY_SECOND) ? PSL_KEY_ARMED : PSL_KEY_IDLE;
                end
                // armed write is consumed either way
                PSL_KEY_ARMED: begin
                    next_key_state = PSL_KEY_IDLE;
                end
                default: begin
                    next_key_state = PSL_KEY_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // lock bit and one-way tracking
    always_comb begin
        next_lock = selection_lock_bit;
        next_ow_state = ow_state;
        if (lock_wr && key_state == PSL_KEY_ARMED) begin
            if (!one_way_lock_option) begin
                next_lock = want_lock;
            end else begin
                unique case (ow_state)
                    PSL_OW_FRESH: begin
                        next_lock = want_lock;
                        if (!want_lock) begin
                            next_ow_state = PSL_OW_CLEARED;
                        end
                    end
                    PSL_OW_CLEARED: begin
                        next_lock = want_lock;
                        if (want_lock) begin
                            next_ow_state = PSL_OW_FROZEN;
                        end
                    end
                    PSL_OW_FROZEN: begin
                        next_lock = 1'b1;
                    end
                    default: begin
                        next_ow_state = PSL_OW_FROZEN;
                        next_lock = 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // selection write gate
    // writes pass only when unlocked
    assign sel_wr_ok = sel_wr & ~selection_lock_bit;
    assign next_blocked = sel_wr & selection_lock_bit;

    // ==========================================
    // registers
    always_ff @(posedge clk) begin
        if (any_reset) begin
            key_state <= PSL_KEY_IDLE;
            ow_state <= PSL_OW_FRESH;
            selection_lock_bit <= 1'b0;
            sel_wr_blocked <= 1'b0;
        end else begin
            key_state <= next_key_state;
            ow_state <= next_ow_state;
            selection_lock_bit <= next_lock;
            sel_wr_blocked <= next_blocked;
        end
    end

    assign key_armed = (key_state == PSL_KEY_ARMED);

    // ==========================================
    // selection storage
    // table ignores non-por resets
    psl_sel_table u_table (
        .clk(clk),
        .por(por),
        .wr_en(sel_wr_ok),
        .wr_idx(sel_idx),
        .wr_data(sel_wdata),
        .rd_idx(sel_rd_idx),
        .rd_data(sel_rdata)
    );

endmodule : psl_lock_ctrl

// >>> rtl/psl_pkg.sv
package psl_pkg;
    // key sequence position
    typedef enum logic [1:0] {
        PSL_KEY_IDLE,
        PSL_KEY_GOT_FIRST,
        PSL_KEY_ARMED
    } psl_key_state_t;

    // one-way lock progress
    typedef enum logic [1:0] {
        PSL_OW_FRESH,
        PSL_OW_CLEARED,
        PSL_OW_FROZEN
    } psl_ow_state_t;
endpackage : psl_pkg

// >>> rtl/psl_sel_table.sv
`timescale 1ns/10ps
`include "psl_defines.svh"

// selection storage; cleared only by power-on reset
module psl_sel_table
    import psl_pkg::*;
(
    // clock and power-on reset
    input wire logic clk,
    input wire logic por,
    // write side
    input wire logic wr_en,
    input wire logic [`PSL_SEL_AW-1:0] wr_idx,
    input wire logic [`PSL_SEL_WIDTH-1:0] wr_data,
    // read side
    input wire logic [`PSL_SEL_AW-1:0] rd_idx,
    output logic [`PSL_SEL_WIDTH-1:0] rd_data
);

    logic [`PSL_SEL_WIDTH-1:0] sel [`PSL_SEL_COUNT];
    logic [`PSL_SEL_WIDTH-1:0] next_sel [`PSL_SEL_COUNT];

    // ==========================================
    // next values
    always_comb begin
        for (int i = 0; i < `PSL_SEL_COUNT; i++) begin
            if (por) begin
                next_sel[i] = `PSL_SEL_DEFAULT;
            end else if (wr_en && wr_idx == i[`PSL_SEL_AW-1:0]) begin
                next_sel[i] = wr_data;
            end else begin
                next_sel[i] = sel[i];
            end
        end
    end

    // ==========================================
    // registers
    always_ff @(posedge clk) begin
        for (int i = 0; i < `PSL_SEL_COUNT; i++) begin
            sel[i] <= next_sel[i];
        end
    end

    assign rd_data = sel[rd_idx];

endmodule : psl_sel_table

// >>> verification/psl_lock_ctrl_test.sv
`timescale 1ns/10ps
module psl_lock_ctrl_test;
    logic clk = 0, reset = 1, por = 1, sleep = 0, one_way_lock_option = 0;
    logic lock_wr = 0, sel_wr = 0, lk = 0;
    logic [7:0] lock_wdata = 8'h00;
    logic [3:0] sel_idx = 4'h0, sel_rd_idx = 4'h0;
    logic [5:0] sel_wdata = 6'h00, sel_rdata;
    logic selection_lock_bit, key_armed, sel_wr_blocked;
    logic [5:0] shadow [16];
    logic [6:0] notes [$];
    int failures = 0, samples_checked = 0;
    event look;
    always #2.5 clk = ~clk;
    psl_lock_ctrl i_dut (.*);
    task automatic test_done;
        $display("checked=%0d failures=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [6:0] seen, input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : cmp
    task automatic lw(input logic [7:0] d);
        @(negedge clk) lock_wr = 1;
        lock_wdata = d;
        @(negedge clk) lock_wr = 0;
    endtask : lw
    task automatic key(input logic v, input logic e);
        lw(8'h55);
        lw(8'haa);
        lw({7'h00, v});
        lk = e;
    endtask : key
    task automatic sw(input logic [3:0] i, input logic [5:0] d);
        @(negedge clk) sel_wr = 1;
        sel_idx = i;
        sel_wdata = d;
        if (!lk) shadow[i] = d;
        @(negedge clk) sel_wr = 0;
    endtask : sw
    task automatic ex(input logic [3:0] i);
        @(negedge clk) sel_rd_idx = i;
        notes.push_back({lk, shadow[i]});
        ->look;
    endtask : ex
    // ==========
    // result watcher
    always @(look) begin
        @(posedge clk) #1;
        cmp({selection_lock_bit, sel_rdata}, notes.pop_front());
    end
    initial begin
        #20000;
        failures++;
        test_done();
    end
    initial begin
        void'($urandom(32'h1d731d7d));
        foreach (shadow[i]) shadow[i] = 6'h00;
        repeat (4) @(posedge clk);
        @(negedge clk) reset = 0;
        por = 0;
        for (int i = 0; i < 16; i++) sw(4'(i), 6'($urandom));
        key(1'b1, 1'b1);
        sw(4'h3, ~shadow[3]);
        cmp({6'h00, sel_wr_blocked}, 7'h01);
        ex(4'h3);
        lw(8'h55);
        lw(8'h00);
        lw(8'haa);
        lw(8'h00);
        ex(4'h3);
        key(1'b0, 1'b0);
        sleep = 1;
        sw(4'hf, 6'($urandom));
        ex(4'hf);
        sleep = 0;
        @(negedge clk) reset = 1;
        @(negedge clk) reset = 0;
        ex(4'hf);
        one_way_lock_option = 1;
        key(1'b1, 1'b1);
        key(1'b0, 1'b0);
        sw(4'h5, 6'($urandom));
        key(1'b1, 1'b1);
        key(1'b0, 1'b1);
        sw(4'h5, ~shadow[5]);
        ex(4'h5);
        @(negedge clk) por = 1;
        // por also drops the lock bit, so the expected lock goes with it
        lk = 0;
        foreach (shadow[i]) shadow[i] = 6'h00;
        @(negedge clk) por = 0;
        for (int i = 0; i < 16; i++) ex(4'(i));
        key(1'b1, 1'b1);
        key(1'b0, 1'b0);
        ex(4'h5);
        repeat (2) @(negedge clk);
        test_done();
    end
endmodule : psl_lock_ctrl_test
bind psl_lock_ctrl psl_lock_props i_props (.*);

// >>> verification/psl_lock_props.sv
`timescale 1ns/10ps
`include "psl_defines.svh"
module psl_lock_props (
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic por,
    input wire logic one_way_lock_option,
    input wire logic lock_wr,
    input wire logic [7:0] lock_wdata,
    input wire logic sel_wr,
    input wire logic [`PSL_SEL_AW-1:0] sel_rd_idx,
    input wire logic [`PSL_SEL_WIDTH-1:0] sel_rdata,
    input wire logic selection_lock_bit,
    input wire logic key_armed,
    input wire logic sel_wr_blocked
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset || por);
    // ==========
    // one-way progress mirror
    logic ow_clr;
    logic ow_frz;
    wire acc = key_armed && lock_wr && one_way_lock_option;
    always_ff @(posedge clk) begin
        ow_clr <= !(reset || por) && (ow_clr || (acc && !lock_wdata[0]));
        ow_frz <= !(reset || por) && (ow_frz || (acc && ow_clr && lock_wdata[0]));
    end
    a_lock_blocks: assert property (selection_lock_bit && sel_wr |=> sel_wr_blocked)
        else $error("write not blocked");
    a_data_cause: assert property ($changed(sel_rdata) && $stable(sel_rd_idx) |->
        $past(sel_wr && !selection_lock_bit || por)) else $error("selection changed");
    a_key_needed: assert property (!(key_armed && lock_wr) |=> $stable(selection_lock_bit))
        else $error("lock changed without key");
    a_armed_from_key: assert property ($rose(key_armed) |->
        $past(lock_wr && lock_wdata == `PSL_KEY_SECOND)) else $error("armed without key");
    a_armed_applies: assert property (key_armed && lock_wr && !ow_frz |=> !key_armed &&
        selection_lock_bit == $past(lock_wdata[`PSL_LOCK_BIT])) else $error("armed write lost");
    a_frozen_holds: assert property (ow_frz |-> selection_lock_bit)
        else $error("frozen lock cleared");
    a_reset_clears: assert property ($past(reset || por) |-> !selection_lock_bit && !key_armed)
        else $error("lock kept over reset");
    a_por_default: assert property ($past(por) |-> sel_rdata == `PSL_SEL_DEFAULT)
        else $error("selection not default");
    cover property (key_armed && lock_wr);
    cover property (sel_wr_blocked);
    cover property (ow_frz && key_armed && lock_wr);
endmodule : psl_lock_props
